// File: shared/rtc_pkg.sv
package rtc_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int HALF_SEC_NS   = 500000000;
   // sub-second counter runs on the clock divided by two
   localparam int HALF_SEC_CYC  = HALF_SEC_NS / CLK_PERIOD_NS / 2;
   localparam logic [25:0] SUBSEC_RELOAD_DEF = 26'(HALF_SEC_CYC - 1);
   localparam int TM_W = 18;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000, OFS_STAT = 12'h004;
   localparam logic [11:0] OFS_SEC  = 12'h008, OFS_MIN  = 12'h00C, OFS_HOUR = 12'h010;
   localparam logic [11:0] OFS_DAY  = 12'h014, OFS_WDAY = 12'h018, OFS_MON  = 12'h01C;
   localparam logic [11:0] OFS_YEAR = 12'h020, OFS_ALMI = 12'h024, OFS_ALARM_HOUR_SETTING = 12'h028;
   localparam logic [11:0] OFS_ALDY = 12'h02C, OFS_ALMO = 12'h030, OFS_ALARM_YEAR_SETTING = 12'h034;
   localparam logic [11:0] OFS_TML  = 12'h038, OFS_TMM  = 12'h03C, OFS_TMH  = 12'h040;
   localparam logic [11:0] OFS_SUBS = 12'h044;

   // ------------------------------------------------------------
   // field masks and bit positions
   // ------------------------------------------------------------
   localparam logic [7:0] MASK_SEC = 8'h7F, MASK_HOUR = 8'h3F, MASK_DAY = 8'h3F;
   localparam logic [7:0] MASK_WDAY = 8'h07, MASK_MON = 8'h1F, MASK_YEAR = 8'hFF;
   localparam logic [7:0] MASK_TMH = 8'h03;
   localparam int CTL_RUN = 0, CTL_CONT = 1, CTL_READ = 2, CTL_WRITE = 3;
   localparam int CTL_TIMER_START_BIT = 4, CTL_TIMER_MODE_SELECT = 5, CTL_EN = 8, EN_W = 5;
   localparam int ST_BUSY = 0, ST_COPY = 1, ST_ERR = 2, ST_TMRUN = 3;

   // ------------------------------------------------------------
   // packed decimal limits
   // ------------------------------------------------------------
   localparam logic [7:0] BCD_ZERO = 8'h00, BCD_ONE = 8'h01, SEC_LAST = 8'h59;
   localparam logic [7:0] HOUR_LAST = 8'h23, WDAY_LAST = 8'h06, MON_LAST = 8'h12;
   localparam logic [7:0] YEAR_LAST = 8'h99, FEB = 8'h02, APR = 8'h04, JUN = 8'h06;
   localparam logic [7:0] SEP = 8'h09, NOV = 8'h11;
   localparam logic [7:0] D28 = 8'h28, D29 = 8'h29, D30 = 8'h30, D31 = 8'h31;

   typedef struct packed {
      logic [7:0] year, mon, wday, day, hour, min, sec;
   } cal_t;
   typedef struct packed {
      logic [7:0] year, mon, day, hour, min;
   } alm_t;
   typedef struct packed {
      logic alarm, hourly, minute, second, half, timer, rwerr, rddone;
   } evt_t;
endpackage

// File: hw/rtc_count_block.sv
`timescale 1ns/1ns
module rtc_count_block #(
   parameter logic [25:0] SUBSEC_RELOAD = rtc_pkg::SUBSEC_RELOAD_DEF // half-second reload
) (
   input  wire logic         clk,        // 125 MHz clock
   input  wire logic         sys_rst,    // async reset, high
   input  wire logic         psel,       // apb select
   input  wire logic         penable,    // apb access phase
   input  wire logic         pwrite,     // apb direction
   input  wire logic [11:0]  paddr,      // apb byte address
   input  wire logic [31:0]  pwdata,     // apb write data
   output      logic [31:0]  prdata,     // apb read data
   output      logic         pready,     // apb ready
   output      logic         pslverr,    // unmapped address
   output rtc_pkg::evt_t     events,     // one-cycle event pulses
   output      logic         half_pulse  // pulse every half second
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   rtc_pkg::cal_t              treg_ff, nxt_treg, cnt_ff, nxt_cnt;
   rtc_pkg::alm_t              alm_ff, nxt_alm;
   rtc_pkg::evt_t              evt_ff, nxt_evt;
   logic                       run_ff, nxt_run, cont_ff, nxt_cont, busy_ff, nxt_busy;
   logic                       read_ff, nxt_read, write_ff, nxt_write, err_ff, nxt_err;
   logic                       pend_ff, nxt_pend, div_ff, nxt_div, phase_ff, nxt_phase;
   logic                       timer_start_bit_ff, nxt_timer_start_bit, timer_mode_select_ff, nxt_timer_mode_select;
   logic [rtc_pkg::EN_W-1:0]   alen_ff, nxt_alen, en_new;
   logic [rtc_pkg::TM_W-1:0]   tset_ff, nxt_tset, tcnt_ff, nxt_tcnt;
   logic [25:0]                subrl_ff, nxt_subrl, sub_ff, nxt_sub;
   logic [31:0]                prdata_ff, nxt_prdata, rdata;
   logic                       tick, hold, sec_go, min_chg, err_set, c, wc, hit, wr_en;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // packed decimal increment, returns {carry, value}
   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
      if (v == last) return {1'b1, first};
      if (v[3:0] == 4'h9) return {1'b0, v[7:4] + 4'h1, 4'h0};
      return {1'b0, v + 8'h01};
   endfunction

   // year divisible by four in packed decimal; year 00 counts as leap
   function automatic logic is_leap(input logic [7:0] y);
      if (y[4]) return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
      if (m == rtc_pkg::FEB) return is_leap(y) ? rtc_pkg::D29 : rtc_pkg::D28;
      if (m == rtc_pkg::APR || m == rtc_pkg::JUN || m == rtc_pkg::SEP || m == rtc_pkg::NOV)
         return rtc_pkg::D30;
      return rtc_pkg::D31;
   endfunction

   // ------------------------------------------------------------
   // apb decode and read mux
   // ------------------------------------------------------------
   assign wr_en   = psel & penable & pwrite;
   assign pready  = 1'b1;            // read data is captured in the setup cycle
   assign pslverr = psel & penable & ~hit;
   assign prdata  = prdata_ff;
   assign events  = evt_ff;
   assign half_pulse = evt_ff.half;

   // reserved bits come back as zero because only masked fields are stored
   always_comb begin
      hit   = 1'b1;
      rdata = '0;
      unique case (paddr)
         rtc_pkg::OFS_CTRL: begin
            rdata[rtc_pkg::CTL_RUN]   = run_ff;
            rdata[rtc_pkg::CTL_CONT]  = cont_ff;
            rdata[rtc_pkg::CTL_READ]  = read_ff;
            rdata[rtc_pkg::CTL_WRITE] = write_ff;
            rdata[rtc_pkg::CTL_TIMER_START_BIT]  = timer_start_bit_ff;
            rdata[rtc_pkg::CTL_TIMER_MODE_SELECT]  = timer_mode_select_ff;
            rdata[rtc_pkg::CTL_EN +: rtc_pkg::EN_W] = alen_ff;
         end
         rtc_pkg::OFS_STAT: begin
            rdata[rtc_pkg::ST_BUSY]  = busy_ff;
            rdata[rtc_pkg::ST_COPY]  = busy_ff | read_ff | write_ff;
            rdata[rtc_pkg::ST_ERR]   = err_ff;
            rdata[rtc_pkg::ST_TMRUN] = timer_start_bit_ff;
         end
         rtc_pkg::OFS_SEC:  rdata[7:0] = treg_ff.sec;
         rtc_pkg::OFS_MIN:  rdata[7:0] = treg_ff.min;
         rtc_pkg::OFS_HOUR: rdata[7:0] = treg_ff.hour;
         rtc_pkg::OFS_DAY:  rdata[7:0] = treg_ff.day;
         rtc_pkg::OFS_WDAY: rdata[7:0] = treg_ff.wday;
         rtc_pkg::OFS_MON:  rdata[7:0] = treg_ff.mon;
         rtc_pkg::OFS_YEAR: rdata[7:0] = treg_ff.year;
         rtc_pkg::OFS_ALMI: rdata[7:0] = alm_ff.min;
         rtc_pkg::OFS_ALARM_HOUR_SETTING: rdata[7:0] = alm_ff.hour;
         rtc_pkg::OFS_ALDY: rdata[7:0] = alm_ff.day;
         rtc_pkg::OFS_ALMO: rdata[7:0] = alm_ff.mon;
         rtc_pkg::OFS_ALARM_YEAR_SETTING: rdata[7:0] = alm_ff.year;
         rtc_pkg::OFS_TML:  rdata[7:0] = tset_ff[7:0];
         rtc_pkg::OFS_TMM:  rdata[7:0] = tset_ff[15:8];
         rtc_pkg::OFS_TMH:  rdata[1:0] = tset_ff[17:16];
         rtc_pkg::OFS_SUBS: rdata[25:0] = subrl_ff;
         default:           hit = 1'b0;
      endcase
   end

   // half-second tick from the divided-clock sub-second counter
   assign tick = run_ff & div_ff & (sub_ff == '0);
   // seconds are held back while a continued rewrite is open or transferring
   assign hold = cont_ff | busy_ff;
   assign en_new = pwdata[rtc_pkg::CTL_EN +: rtc_pkg::EN_W] & ~alen_ff;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      nxt_treg = treg_ff;  nxt_cnt = cnt_ff;   nxt_alm = alm_ff;    nxt_evt = '0;
      nxt_run = run_ff;    nxt_cont = cont_ff; nxt_busy = busy_ff;  nxt_read = read_ff;
      nxt_write = write_ff; nxt_err = err_ff;  nxt_pend = pend_ff;  nxt_div = ~div_ff;
      nxt_phase = phase_ff; nxt_timer_start_bit = timer_start_bit_ff; nxt_timer_mode_select = timer_mode_select_ff; nxt_alen = alen_ff;
      nxt_tset = tset_ff;  nxt_tcnt = tcnt_ff; nxt_subrl = subrl_ff; nxt_sub = sub_ff;
      nxt_prdata = prdata_ff;
      sec_go = 1'b0; min_chg = 1'b0; err_set = 1'b0; c = 1'b0; wc = 1'b0;

      if (run_ff && div_ff) nxt_sub = tick ? subrl_ff : sub_ff - 26'h0000001;
      if (tick) begin
         nxt_evt.half = 1'b1;
         nxt_phase    = ~phase_ff;
         if (phase_ff) begin
            if (hold) begin
               err_set  = pend_ff;
               nxt_pend = 1'b1;
            end else begin
               sec_go = 1'b1;
            end
         end
      end
      if (pend_ff && !hold && !tick) begin
         sec_go   = 1'b1;
         nxt_pend = 1'b0;
      end

      // calendar carry chain with leap year
      if (sec_go) begin
         nxt_evt.second = 1'b1;
         {c, nxt_cnt.sec} = bcd_inc(cnt_ff.sec, rtc_pkg::SEC_LAST, rtc_pkg::BCD_ZERO);
         if (c) begin
            min_chg = 1'b1;
            nxt_evt.minute = 1'b1;
            {c, nxt_cnt.min} = bcd_inc(cnt_ff.min, rtc_pkg::SEC_LAST, rtc_pkg::BCD_ZERO);
         end
         if (c) begin
            nxt_evt.hourly = 1'b1;
            {c, nxt_cnt.hour} = bcd_inc(cnt_ff.hour, rtc_pkg::HOUR_LAST, rtc_pkg::BCD_ZERO);
         end
         if (c) begin
            {wc, nxt_cnt.wday} = bcd_inc(cnt_ff.wday, rtc_pkg::WDAY_LAST, rtc_pkg::BCD_ZERO);
            {c, nxt_cnt.day} = bcd_inc(cnt_ff.day, month_last(cnt_ff.mon, cnt_ff.year),
                                       rtc_pkg::BCD_ONE);
         end
         if (c) {c, nxt_cnt.mon} = bcd_inc(cnt_ff.mon, rtc_pkg::MON_LAST, rtc_pkg::BCD_ONE);
         if (c) {c, nxt_cnt.year} = bcd_inc(cnt_ff.year, rtc_pkg::YEAR_LAST, rtc_pkg::BCD_ZERO);
      end

      // each enabled field must match; checked on minute change
      if (min_chg && (alen_ff != '0)
          && (!alen_ff[0] || nxt_cnt.min  == alm_ff.min)
          && (!alen_ff[1] || nxt_cnt.hour == alm_ff.hour)
          && (!alen_ff[2] || nxt_cnt.day  == alm_ff.day)
          && (!alen_ff[3] || nxt_cnt.mon  == alm_ff.mon)
          && (!alen_ff[4] || nxt_cnt.year == alm_ff.year))
         nxt_evt.alarm = 1'b1;

      // closing transfer loads the rewritten time
      if (busy_ff && !cont_ff) begin
         nxt_cnt  = treg_ff;
         nxt_busy = 1'b0;
      end
      if (write_ff) begin
         nxt_cnt   = treg_ff;
         nxt_write = 1'b0;
      end
      // read completion after counters are copied out
      if (read_ff) begin
         nxt_treg = cnt_ff;
         nxt_read = 1'b0;
         nxt_evt.rddone = 1'b1;
      end

      if (tick && timer_start_bit_ff) begin
         if (tcnt_ff == '0) begin
            nxt_evt.timer = 1'b1;
            if (timer_mode_select_ff) nxt_tcnt = tset_ff;
            else nxt_timer_start_bit = 1'b0;
         end else begin
            nxt_tcnt = tcnt_ff - 18'h00001;
         end
      end

      // software writes take effect in the access phase
      if (wr_en) begin
         unique case (paddr)
            rtc_pkg::OFS_CTRL: begin
               nxt_run = pwdata[rtc_pkg::CTL_RUN];
               if (pwdata[rtc_pkg::CTL_RUN] && !run_ff) begin
                  nxt_cnt   = treg_ff;
                  nxt_sub   = subrl_ff;
                  nxt_phase = 1'b0;
               end
               if (pwdata[rtc_pkg::CTL_CONT] && run_ff && !(busy_ff && !cont_ff)) begin
                  nxt_cont = 1'b1;
                  nxt_busy = 1'b1;
               end else if (!pwdata[rtc_pkg::CTL_CONT] && cont_ff) begin
                  nxt_cont = 1'b0;
                  nxt_err  = 1'b0;   // error clears when the rewrite is closed
               end
               if (pwdata[rtc_pkg::CTL_READ]) nxt_read = 1'b1;
               if (pwdata[rtc_pkg::CTL_WRITE]) nxt_write = 1'b1;
               nxt_timer_start_bit = pwdata[rtc_pkg::CTL_TIMER_START_BIT];
               if (pwdata[rtc_pkg::CTL_TIMER_START_BIT] && !timer_start_bit_ff) nxt_tcnt = tset_ff;
               nxt_timer_mode_select = pwdata[rtc_pkg::CTL_TIMER_MODE_SELECT];
               nxt_alen = pwdata[rtc_pkg::CTL_EN +: rtc_pkg::EN_W];
               // newly set enable fires the alarm at once
               if (en_new != '0) nxt_evt.alarm = 1'b1;
            end
            rtc_pkg::OFS_SEC:  nxt_treg.sec  = pwdata[7:0] & rtc_pkg::MASK_SEC;
            rtc_pkg::OFS_MIN:  nxt_treg.min  = pwdata[7:0] & rtc_pkg::MASK_SEC;
            rtc_pkg::OFS_HOUR: nxt_treg.hour = pwdata[7:0] & rtc_pkg::MASK_HOUR;
            rtc_pkg::OFS_DAY:  nxt_treg.day  = pwdata[7:0] & rtc_pkg::MASK_DAY;
            rtc_pkg::OFS_WDAY: nxt_treg.wday = pwdata[7:0] & rtc_pkg::MASK_WDAY;
            rtc_pkg::OFS_MON:  nxt_treg.mon  = pwdata[7:0] & rtc_pkg::MASK_MON;
            rtc_pkg::OFS_YEAR: nxt_treg.year = pwdata[7:0] & rtc_pkg::MASK_YEAR;
            rtc_pkg::OFS_ALMI: nxt_alm.min   = pwdata[7:0] & rtc_pkg::MASK_SEC;
            rtc_pkg::OFS_ALARM_HOUR_SETTING: nxt_alm.hour  = pwdata[7:0] & rtc_pkg::MASK_HOUR;
            rtc_pkg::OFS_ALDY: nxt_alm.day   = pwdata[7:0] & rtc_pkg::MASK_DAY;
            rtc_pkg::OFS_ALMO: nxt_alm.mon   = pwdata[7:0] & rtc_pkg::MASK_MON;
            rtc_pkg::OFS_ALARM_YEAR_SETTING: nxt_alm.year  = pwdata[7:0] & rtc_pkg::MASK_YEAR;
            rtc_pkg::OFS_TML:  nxt_tset[7:0]   = pwdata[7:0];
            rtc_pkg::OFS_TMM:  nxt_tset[15:8]  = pwdata[7:0];
            rtc_pkg::OFS_TMH:  nxt_tset[17:16] = pwdata[1:0];
            rtc_pkg::OFS_SUBS: nxt_subrl = pwdata[25:0];
            default: ;
         endcase
      end
      // rewrite error: the set wins over a clear in the same cycle
      if (err_set) begin
         nxt_err = 1'b1;
         nxt_evt.rwerr = 1'b1;
      end
      if (psel && !penable && !pwrite) nxt_prdata = rdata;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         treg_ff <= '0;  cnt_ff <= '0;    alm_ff <= '0;   evt_ff <= '0;
         run_ff <= 1'b0; cont_ff <= 1'b0; busy_ff <= 1'b0; read_ff <= 1'b0;
         write_ff <= 1'b0; err_ff <= 1'b0; pend_ff <= 1'b0; div_ff <= 1'b0;
         phase_ff <= 1'b0; timer_start_bit_ff <= 1'b0; timer_mode_select_ff <= 1'b0; alen_ff <= '0;
         tset_ff <= '0;  tcnt_ff <= '0;   subrl_ff <= SUBSEC_RELOAD; sub_ff <= '0;
         prdata_ff <= '0;
      end else begin
         treg_ff <= nxt_treg;  cnt_ff <= nxt_cnt;   alm_ff <= nxt_alm;   evt_ff <= nxt_evt;
         run_ff <= nxt_run;    cont_ff <= nxt_cont; busy_ff <= nxt_busy; read_ff <= nxt_read;
         write_ff <= nxt_write; err_ff <= nxt_err;  pend_ff <= nxt_pend; div_ff <= nxt_div;
         phase_ff <= nxt_phase; timer_start_bit_ff <= nxt_timer_start_bit; timer_mode_select_ff <= nxt_timer_mode_select; alen_ff <= nxt_alen;
         tset_ff <= nxt_tset;  tcnt_ff <= nxt_tcnt; subrl_ff <= nxt_subrl; sub_ff <= nxt_sub;
         prdata_ff <= nxt_prdata;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_reserved_read: assert property (
      psel && !penable && !pwrite && paddr == rtc_pkg::OFS_ALARM_HOUR_SETTING |=> prdata[7:6] == 2'b00)
      else $error("alarm hour reserved bits read nonzero");
   a_day_tens: assert property (alm_ff.day[7:6] == 2'b00)
      else $error("alarm day reserved bits set");
   a_month_tens: assert property (alm_ff.mon[7:5] == 3'b000)
      else $error("alarm month reserved bits set");
   a_year_store: assert property (
      wr_en && paddr == rtc_pkg::OFS_ALARM_YEAR_SETTING |=> alm_ff.year == $past(pwdata[7:0]))
      else $error("alarm year not stored");
   a_timer_split: assert property (
      wr_en && paddr == rtc_pkg::OFS_TMH |=> tset_ff[17:16] == $past(pwdata[1:0]))
      else $error("timer high bits not stored");
   a_timer_count: assert property (
      tick && timer_start_bit_ff && tcnt_ff != '0 && !wr_en |=> tcnt_ff == $past(tcnt_ff) - 18'h00001)
      else $error("timer did not decrement");
   a_single_stop: assert property (
      tick && timer_start_bit_ff && !timer_mode_select_ff && tcnt_ff == '0 && !wr_en |=> !timer_start_bit_ff && evt_ff.timer)
      else $error("single timer did not stop");
   a_interval_run: assert property (
      tick && timer_start_bit_ff && timer_mode_select_ff && tcnt_ff == '0 && !wr_en |=> timer_start_bit_ff && tcnt_ff == tset_ff)
      else $error("interval timer did not reload");
   a_enable_alarm: assert property (
      wr_en && paddr == rtc_pkg::OFS_CTRL && en_new != '0 |=> evt_ff.alarm)
      else $error("alarm enable did not fire");
   a_hold_time: assert property (
      cont_ff && !write_ff && !wr_en |=> cnt_ff == $past(cnt_ff))
      else $error("time moved during rewrite");
   // a released parked second may sit right next to a ticked one, so pulses are matched one to one
   a_second_evt: assert property (evt_ff.second == $past(sec_go))
      else $error("second event not a pulse");

   c_timer_expire: cover property (evt_ff.timer);
   c_alarm_match:  cover property (min_chg ##1 evt_ff.alarm);
   c_read_done:    cover property (read_ff ##1 evt_ff.rddone);
   c_rewrite_err:  cover property (evt_ff.rwerr);
endmodule // rtc_count_block

// File: verif/tb_rtc_alarm_and_timer_setting.sv
`timescale 1ns/1ns
module tb_rtc_alarm_and_timer_setting;
   // ------------------------------------------------------------
   // stimulus and observation
   // ------------------------------------------------------------
   logic          clk      = 1'b0;
   logic          sys_rst  = 1'b1;
   logic          psel     = 1'b0;
   logic          penable  = 1'b0;
   logic          pwrite   = 1'b0;
   logic [11:0]   paddr    = 12'h000;
   logic [31:0]   pwdata   = 32'h0000_0000;
   logic [31:0]   prdata, rd;
   logic          pready, pslverr, err_seen, half_pulse;
   rtc_pkg::evt_t events;
   int            errors = 0, n_checks = 0, n_half = 0, n_tmr = 0, n_alm = 0, i;
   int            n_roll = 0, n_rd = 0, n_rwe = 0;
   typedef struct {logic [11:0] a; logic [31:0] w, r;} row_t;
   // written value beside the value that should read back
   // writes include reserved bits and non-decimal digits
   row_t rows [7] = '{'{rtc_pkg::OFS_ALARM_HOUR_SETTING, 32'h0000_00E3, 32'h0000_0023},
                      '{rtc_pkg::OFS_ALDY, 32'h0000_00F1, 32'h0000_0031},
                      '{rtc_pkg::OFS_ALMO, 32'h0000_00F2, 32'h0000_0012},
                      '{rtc_pkg::OFS_ALARM_YEAR_SETTING, 32'h0000_0099, 32'h0000_0099},
                      '{rtc_pkg::OFS_TML,  32'h0000_00A5, 32'h0000_00A5},
                      '{rtc_pkg::OFS_TMM,  32'h0000_005A, 32'h0000_005A},
                      '{rtc_pkg::OFS_TMH,  32'h0000_00FE, 32'h0000_0002}};

   // short reload keeps a half second at eight clocks
   rtc_count_block #(.SUBSEC_RELOAD(26'h0000003)) u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .events(events), .half_pulse(half_pulse));

   // 125 MHz clock
   // clock never stops
   always #4 clk = ~clk;

   // event counters, pulses stand one cycle so every edge is looked at
   always @(posedge clk) begin
      if (half_pulse === 1'b1) n_half++;
      if (events.timer === 1'b1) n_tmr++;
      if (events.alarm === 1'b1) n_alm++;
      // hourly and minute rollovers share one count
      if (events.hourly === 1'b1) n_roll++;
      if (events.minute === 1'b1) n_roll++;
      if (events.rddone === 1'b1) n_rd++;
      if (events.rwerr === 1'b1) n_rwe++;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 7; i++) begin apb(1'b0, rows[i].a, 32'h0); check(rd, 32'h0); end
      for (i = 0; i < 7; i++) begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         check(rd, rows[i].r);
      end
      // unmapped place: error response, reads zero
      apb(1'b1, 12'h048, 32'hFFFF_FFFF);
      check({31'h0, err_seen}, 32'h1);
      apb(1'b0, 12'h048, 32'h0);
      check(rd, 32'h0);
      // one-shot of one second, encoded as 1
      apb(1'b1, rtc_pkg::OFS_TMM, 32'h0);
      apb(1'b1, rtc_pkg::OFS_TMH, 32'h0);
      apb(1'b1, rtc_pkg::OFS_TML, 32'h1);
      n_half = 0;
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_0011);
      for (i = 0; i < 200 && n_tmr == 0; i++) @(posedge clk);
      check(n_tmr, 1);
      check(n_half, 2);
      repeat (40) @(posedge clk);
      check(n_tmr, 1);
      apb(1'b0, rtc_pkg::OFS_CTRL, 32'h0);
      check({31'h0, rd[4]}, 32'h0);
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_0031);
      for (i = 0; i < 300 && n_tmr < 3; i++) @(posedge clk);
      check(n_tmr, 3);
      apb(1'b0, rtc_pkg::OFS_CTRL, 32'h0);
      check({31'h0, rd[4]}, 32'h1);
      // enabling an alarm field fires at once
      n_alm = 0;
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_0101);
      repeat (3) @(posedge clk);
      check(n_alm, 1);
      // enables cleared before alarm and time writes
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_0000);
      apb(1'b1, rtc_pkg::OFS_SEC,  32'h0000_0059);
      apb(1'b1, rtc_pkg::OFS_MIN,  32'h0000_0059);
      apb(1'b1, rtc_pkg::OFS_HOUR, 32'h0000_0023);
      apb(1'b1, rtc_pkg::OFS_DAY,  32'h0000_0028);
      apb(1'b1, rtc_pkg::OFS_MON,  32'h0000_0002);
      apb(1'b1, rtc_pkg::OFS_ALARM_HOUR_SETTING, 32'h0000_0000);
      apb(1'b1, rtc_pkg::OFS_ALDY, 32'h0000_0029);
      apb(1'b1, rtc_pkg::OFS_ALMO, 32'h0000_0002);
      apb(1'b1, rtc_pkg::OFS_ALARM_YEAR_SETTING, 32'h0000_0000);
      // all five fields match at the rollover
      n_alm = 0;
      n_roll = 0;
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_1F01);
      for (i = 0; i < 100 && n_alm < 2; i++) @(posedge clk);
      check(n_alm, 2);
      check(n_roll, 2);
      // read request copies the counters out first
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_1F05);
      apb(1'b0, rtc_pkg::OFS_DAY, 32'h0);
      check(rd, 32'h0000_0029);
      check(n_rd, 1);
      // rewrite held open past one second on purpose
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_1F03);
      apb(1'b1, rtc_pkg::OFS_HOUR, 32'h0000_0012);
      repeat (40) @(posedge clk);
      apb(1'b0, rtc_pkg::OFS_STAT, 32'h0);
      check(rd, 32'h0000_0007);
      check({31'h0, n_rwe != 0}, 32'h1);
      // copy is over before the next write
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_1F01);
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_1F05);
      apb(1'b0, rtc_pkg::OFS_HOUR, 32'h0);
      check(rd, 32'h0000_0012);
      // mid-run reset clears alarm day and busy
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, rtc_pkg::OFS_ALDY, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, rtc_pkg::OFS_STAT, 32'h0);
      check(rd, 32'h0);
      end_sim();
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #(8 * 20000);
      errors++;
      end_sim();
   end
endmodule // tb_rtc_alarm_and_timer_setting
